// File: sps_host_model.sv
// bus host model that drives the serial clock and data lines
`timescale 1ns/1ps
module sps_host_model (
   // bus lines
   output logic o_scl,
   output logic o_sda,
   input wire logic i_sda
);
   // host clock period 1.5 us: high one half-period, low two
   localparam int HP = 500;
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic start();
      o_sda = 1'b1;
      #HP o_scl = 1'b1;
      #HP o_sda = 1'b0;
      #HP o_scl = 1'b0;
      #HP;
   endtask
   task automatic stop();
      o_sda = 1'b0;
      #HP o_scl = 1'b1;
      #HP o_sda = 1'b1;
      #HP;
   endtask
   task automatic level(input logic v, input int ns);
      o_scl = v;
      #ns;
   endtask
   // ninth clock carries the ack; host samples every bit mid-high
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         o_sda = d[i];
         #HP o_scl = 1'b1;
         #(HP/2) q[i] = i_sda;
         #(HP/2) o_scl = 1'b0;
         #HP;
      end
   endtask
endmodule

// File: sps_pkg.sv
// constants and types for the spd serial slave port
package sps_pkg;
   // ---------------------------------------------
   // clock and documented times
   // ---------------------------------------------
   localparam int unsigned SYS_CLK_KHZ = 50_000;
   localparam int unsigned SYS_CLK_PERIOD_NS = 20;
   localparam int unsigned CLOCK_LOW_LIMIT_MIN_MS = 25;
   localparam int unsigned CLOCK_LOW_LIMIT_MAX_MS = 35;
   localparam real POWER_UP_READY_DELAY_MS = 0.5;
   localparam int unsigned INTERNAL_WRITE_DURATION_MS = 4;
   localparam int unsigned GLITCH_FILTER_WIDTH_NS = 50;
   // ---------------------------------------------
   // derived cycle counts
   // ---------------------------------------------
   localparam int unsigned CLOCK_LOW_LIMIT_CYC =
      CLOCK_LOW_LIMIT_MIN_MS * SYS_CLK_KHZ;
   localparam int unsigned CLOCK_LOW_LIMIT_MAX_CYC =
      CLOCK_LOW_LIMIT_MAX_MS * SYS_CLK_KHZ;
   localparam int unsigned POWER_UP_READY_CYC =
      int'($floor(POWER_UP_READY_DELAY_MS * SYS_CLK_KHZ));
   localparam int unsigned INTERNAL_WRITE_CYC =
      INTERNAL_WRITE_DURATION_MS * SYS_CLK_KHZ;
   // a pulse of the filter width touches at most width/period+1 samples
   localparam int unsigned GLITCH_FILTER_CYC =
      GLITCH_FILTER_WIDTH_NS / SYS_CLK_PERIOD_NS + 2;
   // ---------------------------------------------
   // widths and field positions
   // ---------------------------------------------
   localparam int unsigned TO_W = 21;
   localparam int unsigned WR_W = 18;
   localparam int unsigned INIT_W = 15;
   localparam int unsigned GF_W = 2;
   localparam int unsigned N_LINES = 2;
   localparam int unsigned LINE_SCL = 0;
   localparam int unsigned LINE_SDA = 1;
   localparam int unsigned PIN_W = 6;
   localparam int unsigned PIN_SEL_LSB = 2;
   localparam int unsigned PIN_SEL_MSB = 4;
   localparam int unsigned PIN_WP = 5;
   localparam int unsigned ADDR_PRE_MSB = 7;
   localparam int unsigned ADDR_PRE_LSB = 4;
   localparam int unsigned ADDR_SEL_MSB = 3;
   localparam int unsigned ADDR_SEL_LSB = 1;
   localparam int unsigned ADDR_RW_BIT = 0;
   localparam logic [3:0] PRE_MEMORY = 4'ha;
   localparam logic [3:0] PRE_UTILITY = 4'h6;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // ---------------------------------------------
   // types
   // ---------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_WRITE = 3'h3,
      ST_READ = 3'h2,
      ST_SKIP = 3'h6
   } sps_state_t;
   typedef struct packed {
      logic first;
      logic [7:0] data;
   } sps_wr_t;
   typedef struct packed {
      logic mem_hit;
      logic util_hit;
      logic rd;
   } sps_addr_t;
endpackage

// File: sps_serial_port.sv
// serial slave port of a presence-detect memory
//
// Contract
// - after clock low for the limit, drop the frame and release data.
// - never drop the frame for clock low under 25 ms.
// - count clock-low time only between a start and its stop.
// - sample each data bit on the rising serial clock edge.
// - change the sent bit after the falling serial clock edge.
// - only pull the data line low or release it, never drive high.
// - refuse every memory write while write protect is high; the first byte after the address still passes with first set and is acked.
// - accept commands no later than 0.5 ms after power-up reset.
// - ignore pulses up to 50 ns on the i_scl and i_sda event path; link flops see raw i_scl_clk and i_sda pulses.
// - no lower clock rate limit except the timeout; host keeps about 667 kHz.
// - take the select address bits from the three select pins.
// - decode preamble, pin select and read/write in the address byte.
// - ninth clock carries the ack; stop sending after a master nack.
`timescale 1ns/1ps
module sps_serial_port
   import sps_pkg::*;
#(
   parameter logic [TO_W-1:0] P_CLOCK_LOW_LIMIT_CYC =
      TO_W'(CLOCK_LOW_LIMIT_CYC),
   parameter logic [INIT_W-1:0] P_POWER_UP_READY_CYC =
      INIT_W'(POWER_UP_READY_CYC),
   parameter logic [WR_W-1:0] P_INTERNAL_WRITE_CYC =
      WR_W'(INTERNAL_WRITE_CYC)
)(
   // system clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // serial clock pin used as link clock
   input wire logic i_scl_clk,
   // serial pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   // strap pins
   input wire logic i_select_pin_bit0,
   input wire logic i_select_pin_bit1,
   input wire logic i_select_pin_bit2,
   input wire logic i_write_protect,
   // memory side
   output sps_wr_t o_wr_pkt,
   output logic o_wr_valid,
   output logic o_wr_commit,
   input wire logic [7:0] i_rd_data,
   output logic o_rd_take,
   output logic [3:0] o_util_cmd,
   output logic o_util_valid,
   // status
   output logic o_ready,
   output logic o_busy,
   output logic o_timeout
);
   localparam logic [GF_W-1:0] GF_LAST = GF_W'(GLITCH_FILTER_CYC - 1);

   function automatic sps_addr_t decode_addr(input logic [7:0] b,
                                             input logic [2:0] sel);
      sps_addr_t r;
      r.mem_hit = (b[ADDR_PRE_MSB:ADDR_PRE_LSB] == PRE_MEMORY) &&
                  (b[ADDR_SEL_MSB:ADDR_SEL_LSB] == sel);
      r.util_hit = (b[ADDR_PRE_MSB:ADDR_PRE_LSB] == PRE_UTILITY);
      r.rd = b[ADDR_RW_BIT];
      return r;
   endfunction

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_meta_q;
   logic [PIN_W-1:0] pin_sync_q;
   logic [GF_W-1:0] gf_cnt_q [N_LINES];
   logic line_q [N_LINES];
   logic scl_prev_q;
   logic sda_prev_q;
   logic link_bit_q;
   logic sda_low_q;
   logic lb_meta_q;
   logic lb_sync_q;
   logic [INIT_W-1:0] init_cnt_q;
   logic ready_q;
   logic [TO_W-1:0] to_cnt_q;
   logic to_hit;
   logic timeout_q;
   logic active_q;
   logic drive_en_q;
   logic [3:0] bit_cnt_q;
   sps_state_t state_q;
   logic [7:0] rx_shift_q;
   logic [7:0] byte_in;
   sps_addr_t dec;
   logic ack_now;
   logic addr_ack_q;
   logic addr_rd_q;
   logic addr_util_q;
   logic tx_req_q;
   logic [7:0] tx_shift_q;
   logic rd_take_q;
   logic first_q;
   logic wrote_q;
   sps_wr_t wr_pkt_q;
   logic wr_valid_q;
   logic commit_q;
   logic [WR_W-1:0] wr_cnt_q;
   logic busy_q;
   logic [3:0] util_cmd_q;
   logic util_valid_q;
   logic scl_f;
   logic sda_f;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic rise_data;
   logic rise_byte;
   logic rise_ack;
   logic wp_s;

   // --------------------------------------------------------
   // pin synchronisers
   // --------------------------------------------------------
   assign pin_raw = {i_write_protect, i_select_pin_bit2,
                     i_select_pin_bit1, i_select_pin_bit0, i_sda, i_scl};

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         pin_meta_q <= 6'h03;
         pin_sync_q <= 6'h03;
      end else begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
      end
   end

   assign wp_s = pin_sync_q[PIN_WP];

   // --------------------------------------------------------
   // glitch filters on clock and data
   // --------------------------------------------------------
   for (genvar g = 0; g < N_LINES; g++) begin : g_flt
      always_ff @(posedge i_ref_clk) begin
         if (i_sys_rst) begin
            gf_cnt_q[g] <= '0;
            line_q[g] <= 1'b1;
         end else if (pin_sync_q[g] == line_q[g]) begin
            gf_cnt_q[g] <= '0;
         end else if (gf_cnt_q[g] == GF_LAST) begin
            gf_cnt_q[g] <= '0;
            line_q[g] <= pin_sync_q[g];
         end else begin
            gf_cnt_q[g] <= gf_cnt_q[g] + 1'b1;
         end
      end

      chk_glitch_hold: assert property (
         @(posedge i_ref_clk) disable iff (i_sys_rst)
         $changed(line_q[g]) |-> $past(gf_cnt_q[g]) == GF_LAST)
         else $error("filtered line moved before hold time");
   end

   assign scl_f = line_q[LINE_SCL];
   assign sda_f = line_q[LINE_SDA];

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_f;
         sda_prev_q <= sda_f;
      end
   end

   assign scl_rise = scl_f & ~scl_prev_q;
   assign scl_fall = ~scl_f & scl_prev_q;
   assign start_ev = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
   assign stop_ev = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

   // --------------------------------------------------------
   // link clock domain
   // --------------------------------------------------------
   // capture data on rising clock
   always_ff @(posedge i_scl_clk) begin
      if (i_sys_rst) begin
         link_bit_q <= 1'b1;
      end else begin
         link_bit_q <= i_sda;
      end
   end

   always_ff @(negedge i_scl_clk) begin
      if (i_sys_rst) begin
         sda_low_q <= 1'b0;
      end else begin
         sda_low_q <= tx_req_q;
      end
   end

   chk_fall_update: assert property (
      @(negedge i_scl_clk) disable iff (i_sys_rst)
      sda_low_q == $past(tx_req_q))
      else $error("sent bit not taken at falling clock");

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         lb_meta_q <= 1'b1;
         lb_sync_q <= 1'b1;
      end else begin
         lb_meta_q <= link_bit_q;
         lb_sync_q <= lb_meta_q;
      end
   end

   assign o_sda_o = 1'b0;
   assign o_sda_oe = sda_low_q & drive_en_q & active_q;

   // enable only inside a driven frame
   chk_drain_only: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      o_sda_oe |-> !o_sda_o && drive_en_q && state_q != ST_IDLE)
      else $error("data line driven outside a frame");

   // --------------------------------------------------------
   // power-up readiness
   // --------------------------------------------------------
   // ready after fixed delay
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         init_cnt_q <= '0;
         ready_q <= 1'b0;
      end else if (!ready_q) begin
         if (init_cnt_q == P_POWER_UP_READY_CYC - 1'b1) begin
            ready_q <= 1'b1;
         end
         init_cnt_q <= init_cnt_q + 1'b1;
      end
   end

   chk_ready_delay: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      $rose(ready_q) |->
         $past(init_cnt_q) == P_POWER_UP_READY_CYC - 1'b1)
      else $error("ready raised at wrong time");

   // --------------------------------------------------------
   // frame tracking and clock-low timeout
   // --------------------------------------------------------
   assign to_hit = active_q & ~scl_f &
                   (to_cnt_q == P_CLOCK_LOW_LIMIT_CYC - 1'b1);

   // count low time inside a frame
   // the timeout is the only slow-clock limit
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || !active_q || scl_f || to_hit) begin
         to_cnt_q <= '0;
      end else begin
         to_cnt_q <= to_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         timeout_q <= 1'b0;
      end else begin
         timeout_q <= to_hit;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || to_hit || stop_ev) begin
         active_q <= 1'b0;
      end else if (start_ev && ready_q) begin
         active_q <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || to_hit || stop_ev || start_ev) begin
         drive_en_q <= 1'b0;
      end else if (scl_fall && active_q) begin
         drive_en_q <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || start_ev) begin
         bit_cnt_q <= '0;
      end else if (scl_rise && active_q) begin
         bit_cnt_q <= (bit_cnt_q == BIT_ACK) ? 4'h0 : bit_cnt_q + 4'h1;
      end
   end

   chk_limit_release: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      to_hit |=> !active_q && !o_sda_oe && state_q == ST_IDLE)
      else $error("frame kept after clock low limit");

   chk_limit_window: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      o_timeout |-> $past(to_cnt_q) == P_CLOCK_LOW_LIMIT_CYC - 1'b1)
      else $error("timeout at wrong low time");

   chk_idle_no_count: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      !active_q |=> to_cnt_q == '0)
      else $error("low time counted outside a frame");

   // --------------------------------------------------------
   // byte receive and address decode
   // --------------------------------------------------------
   assign rise_data = scl_rise & active_q & (bit_cnt_q <= BIT_LAST);
   assign rise_byte = scl_rise & active_q & (bit_cnt_q == BIT_LAST);
   assign rise_ack = scl_rise & active_q & (bit_cnt_q == BIT_ACK);
   assign byte_in = {rx_shift_q[6:0], lb_sync_q};
   assign dec = decode_addr(byte_in, pin_sync_q[PIN_SEL_MSB:PIN_SEL_LSB]);
   assign ack_now = (dec.mem_hit | dec.util_hit) & ~busy_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         rx_shift_q <= '0;
      end else if (rise_data) begin
         rx_shift_q <= byte_in;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || start_ev) begin
         addr_ack_q <= 1'b0;
         addr_rd_q <= 1'b0;
         addr_util_q <= 1'b0;
      end else if (rise_byte && state_q == ST_ADDR) begin
         addr_ack_q <= ack_now;
         addr_rd_q <= dec.mem_hit & dec.rd;
         addr_util_q <= dec.util_hit;
      end
   end

   chk_rise_sample: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      rise_data |=> rx_shift_q[0] == $past(lb_sync_q))
      else $error("bit not taken at rising clock");

   chk_addr_select: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      rise_byte && state_q == ST_ADDR && !dec.util_hit &&
      byte_in[ADDR_SEL_MSB:ADDR_SEL_LSB] !=
         pin_sync_q[PIN_SEL_MSB:PIN_SEL_LSB]
      |=> !addr_ack_q && !tx_req_q)
      else $error("foreign select acknowledged");

   // --------------------------------------------------------
   // protocol state
   // --------------------------------------------------------
   // master nack ends sending
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || to_hit || stop_ev) begin
         state_q <= ST_IDLE;
      end else if (start_ev && ready_q) begin
         state_q <= ST_ADDR;
      end else if (rise_ack) begin
         unique case (state_q)
            ST_ADDR: begin
               if (!addr_ack_q || addr_util_q) begin
                  state_q <= ST_SKIP;
               end else begin
                  state_q <= addr_rd_q ? ST_READ : ST_WRITE;
               end
            end
            ST_READ: begin
               if (lb_sync_q) begin
                  state_q <= ST_SKIP;
               end
            end
            ST_IDLE, ST_WRITE, ST_SKIP: begin
               state_q <= state_q;
            end
            default: begin
               state_q <= ST_SKIP;
            end
         endcase
      end
   end

   chk_rw_route: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      rise_ack && state_q == ST_ADDR && addr_ack_q && !addr_util_q
      |=> state_q == (addr_rd_q ? ST_READ : ST_WRITE))
      else $error("address direction not followed");

   chk_nack_end: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      rise_ack && state_q == ST_READ && lb_sync_q
      |=> state_q == ST_SKIP && !tx_req_q && !o_rd_take)
      else $error("sending went on after master nack");

   // --------------------------------------------------------
   // transmit and acknowledge requests
   // --------------------------------------------------------
   // ack on ninth clock
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         tx_req_q <= 1'b0;
         tx_shift_q <= '0;
         rd_take_q <= 1'b0;
      end else if (to_hit || stop_ev || start_ev) begin
         tx_req_q <= 1'b0;
         rd_take_q <= 1'b0;
      end else if (rise_byte) begin
         rd_take_q <= 1'b0;
         if (state_q == ST_ADDR) begin
            tx_req_q <= ack_now;
         end else begin
            tx_req_q <= (state_q == ST_WRITE) && (first_q || !wp_s);
         end
      end else if (rise_ack) begin
         if ((state_q == ST_ADDR && addr_ack_q && addr_rd_q) ||
             (state_q == ST_READ && !lb_sync_q)) begin
            tx_shift_q <= i_rd_data;
            tx_req_q <= ~i_rd_data[7];
            rd_take_q <= 1'b1;
         end else begin
            tx_req_q <= 1'b0;
            rd_take_q <= 1'b0;
         end
      end else if (rise_data) begin
         rd_take_q <= 1'b0;
         tx_req_q <= (state_q == ST_READ) & ~tx_shift_q[6];
         tx_shift_q <= {tx_shift_q[6:0], 1'b0};
      end else begin
         rd_take_q <= 1'b0;
      end
   end

   // --------------------------------------------------------
   // write stream to memory
   // --------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || start_ev) begin
         first_q <= 1'b0;
      end else if (rise_ack && state_q == ST_ADDR) begin
         first_q <= 1'b1;
      end else if (rise_byte && state_q == ST_WRITE) begin
         first_q <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         wr_pkt_q <= '0;
         wr_valid_q <= 1'b0;
      end else if (rise_byte && state_q == ST_WRITE &&
                   (first_q || !wp_s)) begin
         wr_pkt_q <= '{first: first_q, data: byte_in};
         wr_valid_q <= 1'b1;
      end else begin
         wr_valid_q <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || to_hit || stop_ev) begin
         wrote_q <= 1'b0;
      end else if (rise_byte && state_q == ST_WRITE &&
                   !first_q && !wp_s) begin
         wrote_q <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         commit_q <= 1'b0;
      end else begin
         commit_q <= stop_ev & wrote_q;
      end
   end

   chk_wp_block: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      o_wr_valid && !o_wr_pkt.first |-> !$past(wp_s))
      else $error("write passed while protected");

   // --------------------------------------------------------
   // internal write cycle
   // --------------------------------------------------------
   // busy for the write duration
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         busy_q <= 1'b0;
         wr_cnt_q <= '0;
      end else if (commit_q) begin
         busy_q <= 1'b1;
         wr_cnt_q <= '0;
      end else if (busy_q) begin
         if (wr_cnt_q == P_INTERNAL_WRITE_CYC - 1'b1) begin
            busy_q <= 1'b0;
         end
         wr_cnt_q <= wr_cnt_q + 1'b1;
      end
   end

   chk_busy_nack: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      busy_q && rise_byte && state_q == ST_ADDR
      |=> !tx_req_q ##1 state_q != ST_READ)
      else $error("address acked during write cycle");

   // --------------------------------------------------------
   // utility command hand-off
   // --------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         util_cmd_q <= '0;
         util_valid_q <= 1'b0;
      end else if (rise_byte && state_q == ST_ADDR &&
                   dec.util_hit && !busy_q) begin
         util_cmd_q <= byte_in[ADDR_SEL_MSB:ADDR_RW_BIT];
         util_valid_q <= 1'b1;
      end else begin
         util_valid_q <= 1'b0;
      end
   end

   assign o_wr_pkt = wr_pkt_q;
   assign o_wr_valid = wr_valid_q;
   assign o_wr_commit = commit_q;
   assign o_rd_take = rd_take_q;
   assign o_util_cmd = util_cmd_q;
   assign o_util_valid = util_valid_q;
   assign o_ready = ready_q;
   assign o_busy = busy_q;
   assign o_timeout = timeout_q;
endmodule

// File: sps_serial_port_tb.sv
// self-checking bench for the serial slave port
`timescale 1ns/1ps
module sps_serial_port_tb;
   import sps_pkg::*;
   logic clk, rst, scl, hsda, sda, wp, sda_o, sda_oe, busy, tmo, ready;
   logic wr_valid, wr_commit, rd_take, util_valid;
   logic [2:0] sel;
   logic [7:0] rd_data;
   logic [3:0] util_cmd;
   logic [8:0] q;
   logic [31:0] seed = 32'he3bc;
   logic [31:0] d;
   sps_wr_t wr_pkt, wr_last;
   int bad_count, compares, n_wr, n_cm, n_tk, n_ut, n_to, hi_seen, w0, i0;
   assign sda = hsda & ~sda_oe;
   sps_host_model host (.o_scl(scl), .o_sda(hsda), .i_sda(sda));
   sps_serial_port #(
      .P_CLOCK_LOW_LIMIT_CYC(21'd200),
      .P_POWER_UP_READY_CYC(15'd20),
      .P_INTERNAL_WRITE_CYC(18'd1500)
   ) dut (
      .i_ref_clk(clk), .i_sys_rst(rst), .i_scl_clk(scl), .i_scl(scl),
      .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .i_select_pin_bit0(sel[0]), .i_select_pin_bit1(sel[1]),
      .i_select_pin_bit2(sel[2]), .i_write_protect(wp),
      .o_wr_pkt(wr_pkt), .o_wr_valid(wr_valid), .o_wr_commit(wr_commit),
      .i_rd_data(rd_data), .o_rd_take(rd_take), .o_util_cmd(util_cmd),
      .o_util_valid(util_valid), .o_ready(ready), .o_busy(busy),
      .o_timeout(tmo)
   );
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (wr_valid === 1'b1) wr_last = wr_pkt;
      n_wr += (wr_valid === 1'b1);
      n_cm += (wr_commit === 1'b1);
      n_tk += (rd_take === 1'b1);
      n_ut += (util_valid === 1'b1);
      n_to += (tmo === 1'b1);
      hi_seen += (!rst && sda_o !== 1'b0);
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("bad_count %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wait_idle();
      for (w0 = 0; w0 < 2000 && busy !== 1'b0; w0++) @(posedge clk);
      if (w0 == 2000) begin
         bad_count++;
         end_of_test();
      end
   endtask
   initial begin
      rst <= 1'b1;
      wp <= 1'b0;
      sel <= 3'h5;
      rd_data <= 8'h00;
      repeat (2) @(posedge clk);
      // one serial clock pulse so the link flops see reset
      host.level(1'b0, 10);
      host.level(1'b1, 0);
      @(posedge clk);
      rst <= 1'b0;
      for (w0 = 0; w0 < 40 && ready !== 1'b1; w0++) @(negedge clk);
      chk(w0, 21);
      for (int k = 0; k < 4; k++) begin
         seed = xs(seed);
         d = seed;
         @(posedge clk);
         sel <= d[10:8];
         wp <= k[0];
         i0 = n_wr;
         w0 = n_cm;
         @(negedge clk);
         host.start();
         host.xfer({PRE_MEMORY, d[10:8], 2'b01}, q);
         chk(q[0], 0);
         host.xfer({d[23:16], 1'b1}, q);
         host.xfer({d[7:0], 1'b1}, q);
         chk(q[0], k[0]);
         host.stop();
         chk(n_wr - i0, 2 - k[0]);
         chk(wr_last, k[0] ? {1'b1, d[23:16]} : {1'b0, d[7:0]});
         chk(n_cm - w0, !k[0]);
         chk(busy, !k[0]);
         host.start();
         host.xfer({PRE_MEMORY, d[10:8], 2'b01}, q);
         chk(q[0], !k[0]);
         host.stop();
         wait_idle();
      end
      host.start();
      host.xfer({PRE_MEMORY, ~sel, 2'b01}, q);
      chk(q[0], 1);
      host.stop();
      i0 = n_ut;
      host.start();
      host.xfer({PRE_UTILITY, 4'h9, 1'b1}, q);
      chk({q[0], util_cmd, 8'(n_ut - i0)}, {1'b0, 4'h9, 8'h01});
      host.stop();
      seed = xs(seed);
      @(posedge clk);
      rd_data <= seed[7:0];
      wp <= 1'b0;
      i0 = n_tk;
      @(negedge clk);
      host.start();
      host.xfer({PRE_MEMORY, sel, 2'b11}, q);
      host.level(1'b1, 40);
      host.level(1'b0, 500);
      host.xfer(9'h1ff, q);
      chk({q, 8'(n_tk - i0)}, {seed[7:0], 1'b1, 8'h01});
      host.stop();
      host.start();
      host.xfer({PRE_MEMORY, sel, 2'b01}, q);
      #2000;
      i0 = n_to;
      host.xfer({seed[15:8], 1'b1}, q);
      chk({q[0], 8'(n_to - i0)}, 9'h000);
      host.stop();
      // read frame stalled while the device pulls data low
      @(posedge clk);
      rd_data <= {1'b0, seed[14:8]};
      @(negedge clk);
      host.start();
      host.xfer({PRE_MEMORY, sel, 2'b11}, q);
      chk(sda, 0);
      #4500;
      chk({sda, 8'(n_to - i0)}, {1'b1, 8'h01});
      host.stop();
      i0 = n_to;
      host.level(1'b0, 6000);
      host.level(1'b1, 500);
      chk(n_to - i0, 0);
      chk(hi_seen, 0);
      end_of_test();
   end
endmodule
